// File: hdl/dppb_link_ctl.sv
// port b control register, vblank update and link symbol output
`timescale 1ns/1ns
module dppb_link_ctl
    import dppb_pkg::*;
#(
    parameter int SYM_DIV = 4,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [19:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rack,
    input wire logic vblank,
    input wire logic det_strap,
    input wire logic [31:0] tca_data,
    input wire logic tca_valid,
    input wire logic [31:0] tcb_data,
    input wire logic tcb_valid,
    output logic src_ready,
    output logic src_from_b,
    output dppb_pkg::dppb_sym_s [DPPB_LANES-1:0] lane_sym,
    output logic [DPPB_LANES-1:0] lane_oe,
    output logic [2:0] vswing,
    output logic [2:0] preemph,
    output logic scr_init,
    output logic port_b_on
);
    localparam int DW = $clog2(SYM_DIV + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(SYM_DIV - 1);

    // =========================================================
    // state
    logic [31:0] ctl_q;
    logic det_q, det_done_q;
    logic [31:0] rdata_q;
    logic rack_q;
    logic vb_q;
    logic port_on_q, tc_sel_q;
    logic [2:0] lane_cnt_q, swing_q, pe_q;
    dppb_pat_e cur_pat_q;
    logic [DW-1:0] div_q;
    logic tick_q;
    logic scr_q;
    dppb_sym_s [DPPB_LANES-1:0] lane_q;
    logic [DPPB_LANES-1:0] oe_q;

    // =========================================================
    // register decode
    wire hit = reg_addr == DPPB_CTL_OFS;
    wire ctl_wr = reg_wr && hit;
    wire [31:0] ctl_rd = ctl_q | ({31'h0, det_q} << DPPB_DET_BIT);
    wire [1:0] f_pat = ctl_q[DPPB_PAT_LO +: 2];
    wire [2:0] f_sw = ctl_q[DPPB_SW_LO +: 3];
    wire [2:0] f_pe = ctl_q[DPPB_PE_LO +: 3];
    wire [2:0] f_lw = ctl_q[DPPB_LW_LO +: 3];
    wire f_en = ctl_q[DPPB_EN_BIT];
    wire f_sel = ctl_q[DPPB_SEL_BIT];
    // edge of the blank level; applied state lands one clock after it
    wire vb_rise = vblank && !vb_q;

    // register write and read answer; unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= DPPB_CTL_RESET;
            rdata_q <= '0;
            rack_q <= 1'b0;
        end else begin
            if (ctl_wr) begin
                ctl_q <= reg_wdata & DPPB_CTL_WMASK;
            end
            rack_q <= reg_rd;
            rdata_q <= (reg_rd && hit) ? ctl_rd : '0;
        end
    end

    // detect strap caught once, the first cycle after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            det_q <= 1'b0;
            det_done_q <= 1'b0;
        end else if (!det_done_q) begin
            det_q <= det_strap;
            det_done_q <= 1'b1;
        end
    end

    // =========================================================
    // vblank-timed port state; drive levels applied at once
    wire lw_legal = (f_lw == DPPB_LW_X1) || (f_lw == DPPB_LW_X2)
                 || (f_lw == DPPB_LW_X4);
    wire turning_on = vb_rise && f_en && !port_on_q;

    // select applied at vblank, only when enabled
    // lane count only loaded as the port turns on
    always_ff @(posedge mclk) begin
        if (rst) begin
            vb_q <= 1'b0;
            port_on_q <= 1'b0;
            tc_sel_q <= 1'b0;
            lane_cnt_q <= DPPB_LW_X1;
        end else begin
            vb_q <= vblank;
            if (vb_rise) begin
                port_on_q <= f_en;
            end
            if (vb_rise && f_en) begin
                tc_sel_q <= f_sel;
            end
            // reserved lane codes leave the last legal width
            if (turning_on && lw_legal) begin
                lane_cnt_q <= f_lw;
            end
        end
    end

    // reserved level codes keep the previous level
    always_ff @(posedge mclk) begin
        if (rst) begin
            swing_q <= '0;
            pe_q <= '0;
        end else begin
            if (f_sw <= DPPB_LVL_MAX) begin
                swing_q <= f_sw;
            end
            if (f_pe <= DPPB_LVL_MAX) begin
                pe_q <= f_pe;
            end
        end
    end

    // =========================================================
    // link symbol rate: one enable pulse every SYM_DIV clocks
    always_ff @(posedge mclk) begin
        if (rst || !port_on_q) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
            tick_q <= div_q == DIV_LAST;
        end
    end

    // =========================================================
    // pattern sequencing
    dppb_sym_s gen_sym;
    logic gen_end;

    dppb_patgen u_patgen (
        .mclk(mclk),
        .rst(rst || !port_on_q),
        .tick(tick_q),
        .pat(cur_pat_q),
        .sym(gen_sym),
        .seq_end(gen_end)
    );

    wire pat_step = tick_q && gen_end;
    wire tp2_leave = pat_step && cur_pat_q == DPPB_TP2
                  && dppb_pat_e'(f_pat) != DPPB_TP2;

    // pattern field taken at a sequence boundary, or on any cycle while disabled
    // init pulse as the final pattern 2 pass completes
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_pat_q <= DPPB_TP1;
            scr_q <= 1'b0;
        end else begin
            if (!port_on_q || pat_step) begin
                cur_pat_q <= dppb_pat_e'(f_pat);
            end
            scr_q <= port_on_q && tp2_leave;
        end
    end

    // =========================================================
    // pixel path through the fifo
    logic [31:0] pix_data;
    logic pix_valid;
    logic fifo_ready;
    wire is_normal = cur_pat_q == DPPB_NORMAL;
    // pixels are drained only in normal transmission
    wire pix_pop = port_on_q && is_normal && tick_q && pix_valid;
    wire [31:0] src_data = tc_sel_q ? tcb_data : tca_data;
    wire src_valid = port_on_q && (tc_sel_q ? tcb_valid : tca_valid);

    // eight words absorb the symbol-rate gaps; both sources see ready
    // limitation: words left at disable go out after the next enable
    dppb_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(src_valid),
        .in_data(src_data),
        .in_ready(fifo_ready),
        .out_valid(pix_valid),
        .out_ready(pix_pop),
        .out_data(pix_data)
    );

    // =========================================================
    // lane drivers
    // lane mask from the locked lane count
    wire [DPPB_LANES-1:0] lane_mask =
        (lane_cnt_q == DPPB_LW_X4) ? DPPB_LM_X4 :
        (lane_cnt_q == DPPB_LW_X2) ? DPPB_LM_X2 : DPPB_LM_X1;

    genvar gi;
    generate
        for (gi = 0; gi < DPPB_LANES; gi++) begin : g_lane
            // same pattern symbol on every lane, pixel bytes split
            wire dppb_sym_s pix_sym = '{data: pix_data[8*gi +: 8], k: 1'b0};
            always_ff @(posedge mclk) begin
                if (rst || !port_on_q) begin
                    lane_q[gi] <= '0;
                end else if (tick_q && !is_normal) begin
                    lane_q[gi] <= gen_sym;
                end else if (pix_pop) begin
                    lane_q[gi] <= pix_sym;
                end
            end
        end
    endgenerate

    // output enables follow the port state, all off when disabled
    always_ff @(posedge mclk) begin
        if (rst || !port_on_q) begin
            oe_q <= '0;
        end else begin
            oe_q <= lane_mask;
        end
    end

    // =========================================================
    // outputs
    assign reg_rdata = rdata_q;
    assign reg_rack = rack_q;
    assign src_ready = fifo_ready;
    assign src_from_b = tc_sel_q;
    assign lane_sym = lane_q;
    assign lane_oe = oe_q;
    assign vswing = swing_q;
    assign preemph = pe_q;
    assign scr_init = scr_q;
    assign port_b_on = port_on_q;

    // =========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_enable_at_vblank: assert property (
        $changed(port_on_q) |-> $past(vb_rise) && port_on_q == $past(f_en)
    ) else $error("port enable changed outside vblank");

    a_oe_when_off: assert property (
        !port_on_q |=> oe_q == '0
    ) else $error("lane driven while port disabled");

    a_select_at_vblank: assert property (
        $changed(tc_sel_q) |-> $past(vb_rise) && tc_sel_q == $past(f_sel)
    ) else $error("transcoder select changed outside vblank");

    a_select_needs_en: assert property (
        $changed(tc_sel_q) |-> $past(f_en)
    ) else $error("transcoder select applied while disabled");

    a_tp2_whole_seq: assert property (
        port_on_q && $past(port_on_q) && $past(cur_pat_q) == DPPB_TP2
        && cur_pat_q != DPPB_TP2 |-> $past(pat_step)
    ) else $error("pattern 2 left mid sequence");

    a_scr_init_end: assert property (
        scr_init |-> $past(cur_pat_q) == DPPB_TP2 && $past(pat_step)
    ) else $error("scrambler init outside pattern 2 end");

    a_idle_novid: assert property (
        port_on_q && cur_pat_q == DPPB_IDLE && tick_q && !gen_sym.k
        |=> lane_q[0].data == DPPB_VBID_NOVID && !lane_q[0].k
    ) else $error("idle vb-id without no-video flag");

    a_levels_legal: assert property (
        swing_q <= DPPB_LVL_MAX && pe_q <= DPPB_LVL_MAX
    ) else $error("reserved swing or pre-emphasis level applied");

    a_lanes_locked: assert property (
        port_on_q && $past(port_on_q) |-> $stable(lane_cnt_q)
    ) else $error("lane count changed while enabled");

    a_lanes_alike: assert property (
        oe_q[1] && !is_normal |-> lane_q[1] == lane_q[0]
    ) else $error("lanes differ during training");

    a_pix_normal: assert property (
        port_on_q && tick_q && !is_normal |=> lane_q[1] == $past(gen_sym)
    ) else $error("pixel drained outside normal mode");

    a_tp1_symbol: assert property (
        port_on_q && tick_q && cur_pat_q == DPPB_TP1
        |=> lane_q[0].data == DPPB_D10_2 && !lane_q[0].k
    ) else $error("pattern 1 symbol is not d10.2");

    a_off_lanes_zero: assert property (
        !port_on_q |=> lane_q == '0
    ) else $error("lane symbols driven while port disabled");

    a_lane_width_legal: assert property (
        lane_cnt_q == DPPB_LW_X1 || lane_cnt_q == DPPB_LW_X2
        || lane_cnt_q == DPPB_LW_X4
    ) else $error("reserved lane count applied");

    c_port_enable: cover property (turning_on);
    c_two_lanes: cover property (oe_q == DPPB_LM_X2);
    c_tp2_done: cover property (scr_q);
    c_idle_sent: cover property (cur_pat_q == DPPB_IDLE && tick_q);
    c_pixel_out: cover property (pix_pop && tc_sel_q);
endmodule

// File: inc/dppb_pkg.sv
// shared constants and types for the port b link control block
package dppb_pkg;
    // =========================================================
    // register map
    localparam logic [19:0] DPPB_CTL_OFS = 20'hE4100;
    localparam logic [31:0] DPPB_CTL_RESET = 32'h0000_0018;
    // writable bits: 31:19 and sync polarity 4:3
    localparam logic [31:0] DPPB_CTL_WMASK = 32'hFFF8_0018;
    localparam int DPPB_EN_BIT = 31;
    localparam int DPPB_SEL_BIT = 30;
    localparam int DPPB_PAT_LO = 28;
    localparam int DPPB_SW_LO = 25;
    localparam int DPPB_PE_LO = 22;
    localparam int DPPB_LW_LO = 19;
    localparam int DPPB_DET_BIT = 2;

    // =========================================================
    // field encodings
    typedef enum logic [1:0] {
        DPPB_TP1 = 2'h0,
        DPPB_TP2 = 2'h1,
        DPPB_IDLE = 2'h2,
        DPPB_NORMAL = 2'h3
    } dppb_pat_e;
    localparam logic [2:0] DPPB_LW_X1 = 3'h0;
    localparam logic [2:0] DPPB_LW_X2 = 3'h1;
    localparam logic [2:0] DPPB_LW_X4 = 3'h3;
    localparam logic [3:0] DPPB_LM_X1 = 4'h1;
    localparam logic [3:0] DPPB_LM_X2 = 4'h3;
    localparam logic [3:0] DPPB_LM_X4 = 4'hF;
    localparam logic [2:0] DPPB_LVL_MAX = 3'h3;

    // =========================================================
    // link symbols and sequence lengths
    localparam logic [7:0] DPPB_D10_2 = 8'h4A;
    localparam logic [7:0] DPPB_D11_6 = 8'hCB;
    localparam logic [7:0] DPPB_K28_5 = 8'hBC;
    localparam logic [7:0] DPPB_VBID_NOVID = 8'h08;
    localparam logic [3:0] DPPB_TP2_LEN = 4'hA;
    localparam logic [3:0] DPPB_TP2_HEAD = 4'h4;
    localparam logic [3:0] DPPB_IDLE_LEN = 4'hA;
    localparam int DPPB_LANES = 4;

    typedef struct packed {
        logic [7:0] data;
        logic k;
    } dppb_sym_s;
endpackage

// File: hdl/dppb_fifo.sv
// pixel word fifo with registered input ready
`timescale 1ns/1ns
module dppb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ready_q;
    wire push = in_valid && ready_q;
    wire pop = out_valid && out_ready;

    // ready is a flop, so it must look at the next count
    assign cnt_d = cnt_q + CW'(push) - CW'(pop);
    assign in_ready = ready_q;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    // =========================================================
    // storage and pointers
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            ready_q <= cnt_d != FULL_CNT;
        end
    end
endmodule

// File: hdl/dppb_patgen.sv
// training and idle symbol sequencer
`timescale 1ns/1ns
module dppb_patgen
    import dppb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input dppb_pkg::dppb_pat_e pat,
    output dppb_pkg::dppb_sym_s sym,
    output logic seq_end
);
    logic [3:0] idx_q;
    wire is_tp2 = pat == DPPB_TP2;
    wire is_idle = pat == DPPB_IDLE;
    wire [3:0] last_idx = is_tp2 ? DPPB_TP2_LEN - 4'h1
                                 : DPPB_IDLE_LEN - 4'h1;

    // single-symbol patterns end on every symbol
    assign seq_end = !(is_tp2 || is_idle) || (idx_q == last_idx);

    wire tp2_k = is_tp2 && (idx_q < DPPB_TP2_HEAD) && !idx_q[0];
    wire tp2_d11 = is_tp2 && (idx_q < DPPB_TP2_HEAD) && idx_q[0];
    assign sym.k = tp2_k || (is_idle && !idx_q[0]);
    assign sym.data = sym.k ? DPPB_K28_5
                    : tp2_d11 ? DPPB_D11_6
                    : is_idle ? DPPB_VBID_NOVID
                    : DPPB_D10_2;

    // position counter, advanced once per link symbol
    always_ff @(posedge mclk) begin
        if (rst) begin
            idx_q <= '0;
        end else if (tick) begin
            idx_q <= seq_end ? '0 : idx_q + 4'h1;
        end
    end
endmodule

// File: verification/dppb_sink_model.sv
// behavioural sink on the port b main-link lanes
`timescale 1ns/1ns
module dppb_sink_model
    import dppb_pkg::*;
(
    input wire logic mclk,
    input dppb_pkg::dppb_sym_s [dppb_pkg::DPPB_LANES-1:0] lane_sym,
    input wire logic [dppb_pkg::DPPB_LANES-1:0] lane_oe,
    output logic locked
);
    import dppb_pkg::*;
    int run = 0;
    initial locked = 1'b0;

    // ========
    // clock recovery stand-in
    // lock on d10.2
    // a run of d10.2 on a driven lane 0 is needed; floating lanes drop it
    always @(posedge mclk) begin
        if (lane_oe[0] !== 1'b1 || lane_sym[0] !== {DPPB_D10_2, 1'b0}) begin
            run = 0;
        end else begin
            run = run + 1;
        end
        locked <= run > 8;
    end
endmodule

// File: verification/tb.sv
// self-checking bench for the port b link control block
`timescale 1ns/1ns
module tb;
    import dppb_pkg::*;
    localparam int SD = 4;
    localparam logic [19:0] OFS = DPPB_CTL_OFS;
    logic mclk, rst, reg_wr, reg_rd, vblank, det_strap;
    logic [19:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, tca_data, tcb_data, ctl;
    logic reg_rack, tca_valid, tcb_valid, src_ready, src_from_b;
    dppb_sym_s [DPPB_LANES-1:0] lane_sym;
    logic [DPPB_LANES-1:0] lane_oe;
    logic [2:0] vswing, preemph, ev, ep;
    logic scr_init, port_b_on, locked;
    logic [31:0] words [8];
    int num_errors, checks, cyc, scr_cnt, i;

    dppb_link_ctl #(.SYM_DIV(SD), .FIFO_DEPTH(8)) dppb_link_ctl_i (
        .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rack(reg_rack), .vblank(vblank), .det_strap(det_strap),
        .tca_data(tca_data), .tca_valid(tca_valid), .tcb_data(tcb_data),
        .tcb_valid(tcb_valid), .src_ready(src_ready),
        .src_from_b(src_from_b), .lane_sym(lane_sym), .lane_oe(lane_oe),
        .vswing(vswing), .preemph(preemph), .scr_init(scr_init),
        .port_b_on(port_b_on)
    );
    dppb_sink_model dppb_sink_model_i (
        .mclk(mclk), .lane_sym(lane_sym), .lane_oe(lane_oe), .locked(locked)
    );

    // ========
    // clock, scrambler pulse count and hang guard
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (scr_init === 1'b1) begin
            scr_cnt <= scr_cnt + 1;
        end
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    // ========
    // helpers
    task automatic close_out();
        $display("errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [35:0] exp,
        input logic [35:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    // read answer comes one cycle after the strobe edge
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rack", 36'(1), 36'(reg_rack));
        chk("reg_rdata", 36'(exp), 36'(reg_rdata));
        @(posedge mclk);
    endtask
    // vblank rise, then wait until the applied state has landed
    task automatic vb();
        vblank <= 1'b1;
        repeat (3) @(posedge mclk);
        vblank <= 1'b0;
        #1;
    endtask
    // lanes need a bounded wait since symbol ticks are not phase locked
    task automatic see(input logic [35:0] exp);
        for (int n = 0; n < 40 && lane_sym !== exp; n++) begin
            @(posedge mclk);
            #1;
        end
        chk("lane_sym", exp, lane_sym);
    endtask
    function automatic logic [31:0] mk(input logic en, input logic sel,
        input logic [1:0] pat, input logic [2:0] lw);
        return {en, sel, pat, 6'h00, lw, 19'h00018};
    endfunction
    // pixel byte i goes to lane i as a data symbol
    function automatic logic [35:0] px(input logic [31:0] w);
        return {w[31:24], 1'b0, w[23:16], 1'b0, w[15:8], 1'b0, w[7:0], 1'b0};
    endfunction
    // ten symbols of pattern 2, then ten of the idle pattern
    function automatic logic [8:0] seq(input int n);
        if (n >= 10) begin
            return n % 2 ? {DPPB_VBID_NOVID, 1'b0} : {DPPB_K28_5, 1'b1};
        end
        if (n < 4) begin
            return n % 2 ? {DPPB_D11_6, 1'b0} : {DPPB_K28_5, 1'b1};
        end
        return {DPPB_D10_2, 1'b0};
    endfunction

    // ========
    // main sequence
    initial begin
        void'($urandom(32'h9375));
        {rst, det_strap} = 2'b11;
        {reg_wr, reg_rd, vblank, tca_valid, tcb_valid} = 5'h00;
        {reg_addr, reg_wdata, tca_data, tcb_data} = '0;
        {num_errors, checks, cyc, scr_cnt} = '0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(OFS, 32'h0000_001C);
        // random readback, unmapped place ignored and reads zero
        for (i = 0; i < 6; i++) begin
            ctl = $urandom() & 32'h3FFF_FFFF;
            wr(OFS, ctl);
            wr(20'hE4104, ~ctl);
            rd(20'hE4104, 32'h0);
            rd(OFS, (ctl & DPPB_CTL_WMASK) | 32'h4);
        end
        // every swing and pre-emphasis code, reserved ones keep the level
        // random loop leaves some level applied; start both from zero
        wr(OFS, 32'h0);
        {ev, ep} = 6'h00;
        for (i = 0; i < 8; i++) begin
            ctl = mk(1'b0, 1'b0, DPPB_TP1, DPPB_LW_X4);
            wr(OFS, ctl | (32'(i) << 25) | (32'(7 - i) << 22));
            ev = i < 4 ? 3'(i) : ev;
            ep = i > 3 ? 3'(7 - i) : ep;
            @(posedge mclk);
            #1;
            chk("vswing", 36'(ev), 36'(vswing));
            chk("preemph", 36'(ep), 36'(preemph));
        end
        // enable request is held off until the next vblank rise
        wr(OFS, mk(1'b1, 1'b0, DPPB_TP1, DPPB_LW_X4));
        repeat (4) @(posedge mclk);
        #1;
        chk("port_b_on", 36'(0), 36'(port_b_on));
        chk("lane_oe", 36'(0), 36'(lane_oe));
        vb();
        chk("port_b_on", 36'(1), 36'(port_b_on));
        chk("lane_oe", 36'(DPPB_LM_X4), 36'(lane_oe));
        see({4{DPPB_D10_2, 1'b0}});
        // fill the buffer while training, a ninth word is refused
        for (i = 0; i < 8; i++) begin
            words[i] = $urandom();
            tca_data <= words[i];
            tca_valid <= 1'b1;
            @(posedge mclk);
        end
        tca_data <= ~words[7];
        repeat (3) @(posedge mclk);
        tca_valid <= 1'b0;
        #1;
        chk("src_ready", 36'(0), 36'(src_ready));
        chk("locked", 36'(1), 36'(locked));
        // idle requested mid pattern 2, normal mid idle; each waits for the sequence end
        wr(OFS, mk(1'b1, 1'b0, DPPB_TP2, DPPB_LW_X4));
        for (i = 0; i < 40 && lane_sym[0] !== {DPPB_K28_5, 1'b1}; i++) begin
            @(posedge mclk);
            #1;
        end
        fork
            begin
                repeat (8) @(posedge mclk);
                wr(OFS, mk(1'b1, 1'b0, DPPB_IDLE, DPPB_LW_X4));
                repeat (40) @(posedge mclk);
                wr(OFS, mk(1'b1, 1'b0, DPPB_NORMAL, DPPB_LW_X4));
            end
        join_none
        for (i = 0; i < 20; i++) begin
            chk("lane_sym", {4{seq(i)}}, lane_sym);
            repeat (SD) @(posedge mclk);
            #1;
        end
        chk("scr_init", 36'(1), 36'(scr_cnt));
        for (i = 0; i < 8; i++) begin
            see(px(words[i]));
        end
        repeat (12) @(posedge mclk);
        #1;
        chk("lane_sym", px(words[7]), lane_sym);
        // switch to transcoder b at vblank
        wr(OFS, mk(1'b1, 1'b1, DPPB_NORMAL, DPPB_LW_X4));
        vb();
        chk("src_from_b", 36'(1), 36'(src_from_b));
        words[0] = $urandom();
        {tcb_data, tca_data} <= {words[0], ~words[0]};
        {tcb_valid, tca_valid} <= 2'b11;
        see(px(words[0]));
        {tcb_valid, tca_valid} <= 2'b00;
        // disable: select change refused, lanes float
        wr(OFS, mk(1'b0, 1'b0, DPPB_NORMAL, DPPB_LW_X4));
        vb();
        chk("port_b_on", 36'(0), 36'(port_b_on));
        chk("src_from_b", 36'(1), 36'(src_from_b));
        chk("lane_oe", 36'(0), 36'(lane_oe));
        chk("lane_sym", 36'(0), lane_sym);
        // brief enable on transcoder a, one lane latched at turn on
        wr(OFS, mk(1'b1, 1'b0, DPPB_TP1, DPPB_LW_X1));
        vb();
        chk("src_from_b", 36'(0), 36'(src_from_b));
        chk("lane_oe", 36'(DPPB_LM_X1), 36'(lane_oe));
        wr(OFS, mk(1'b1, 1'b0, DPPB_TP1, DPPB_LW_X2));
        vb();
        chk("lane_oe", 36'(DPPB_LM_X1), 36'(lane_oe));
        wr(OFS, mk(1'b0, 1'b0, DPPB_TP1, DPPB_LW_X2));
        vb();
        wr(OFS, mk(1'b1, 1'b0, DPPB_TP1, DPPB_LW_X2));
        vb();
        chk("lane_oe", 36'(DPPB_LM_X2), 36'(lane_oe));
        close_out();
    end
endmodule
